// ==== interrupt_priority_bank_0_4_test.sv ====
/*
 * Self-checking bench of the priority bank against a reference model.
 * Assumes ipb_top, its package and ipb_cpu_model are compiled first.
 */
`timescale 1ns/100ps
module interrupt_priority_bank_0_4_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [19:0] flag = 20'h0;
	logic [31:0] rdat;
	logic ack;
	logic req;
	logic [2:0] lvl;
	logic [4:0] vec;
	logic [15:0] seen;
	logic [4:0] last_vec;
	logic [15:0] m_prio [5];
	logic [19:0] m_en;
	logic [31:0] got;
	logic [7:0] a;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int best;
	int bvec;

	always #2.5 clk_i = ~clk_i;

	ipb_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .flag_i(flag),
		.irq_req_o(req), .irq_level_o(lvl), .irq_vector_o(vec));

	ipb_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.level_i(lvl), .vector_i(vec), .seen_o(seen),
		.last_vector_o(last_vec));

	// Source s sits in register s/4, top field first
	function automatic logic [2:0] m_field(int s);
		return 3'(m_prio[s / 4] >> (12 - 4 * (s % 4)));
	endfunction

	task automatic m_rank();
		best = 0;
		bvec = 0;
		for (int s = 0; s < 20; s++) begin
			if (flag[s] && m_en[s] && m_field(s) > best) begin
				best = m_field(s);
				bvec = s;
			end
		end
	endtask

	function automatic logic [31:0] m_read(logic [7:0] ad);
		if (ad < 8'h14 && ad[1:0] == 2'h0) return {16'h0, m_prio[ad[4:2]]};
		if (ad == 8'h14) return {12'h0, m_en};
		if (ad == 8'h18) begin
			return {15'h0, best != 0, 5'h0, 3'(best), 3'h0, 5'(bvec)};
		end
		return 32'h0;
	endfunction

	task automatic m_write(logic [7:0] ad, logic [31:0] d, logic [3:0] s);
		logic [31:0] w;
		w = m_read(ad);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) w[b*8 +: 8] = d[b*8 +: 8];
		end
		if (ad < 8'h14 && ad[1:0] == 2'h0) m_prio[ad[4:2]] = w[15:0] & 16'h7777;
		if (ad == 8'h14) m_en = w[19:0];
	endtask

	// One classic cycle, held until ack is sampled
	task automatic wb(logic w, logic [7:0] ad, logic [31:0] d, logic [3:0] s);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, d, s};
		do @(posedge clk_i); while (ack !== 1'b1);
		got = rdat;
		{cyc, stb} <= 2'b00;
		if (w) m_write(ad, d, s);
	endtask

	task automatic report(string name, logic [31:0] exp, logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_reg(logic [7:0] ad);
		wb(1'b0, ad, 32'h0, 4'h0);
		m_rank();
		report("register", m_read(ad), got);
	endtask

	// Request settles in one edge; the partner takes it on the second
	task automatic check_irq();
		logic [15:0] s0;
		repeat (2) @(posedge clk_i);
		m_rank();
		s0 = seen;
		@(posedge clk_i);
		report("request", {23'h0, best != 0, 3'(best), 5'(bvec)},
			{23'h0, req, lvl, vec});
		report("partner count", {16'h0, s0 + 16'(best != 0)},
			{16'h0, seen});
		if (best != 0) begin
			report("partner vector", 32'(bvec),
				{27'h0, last_vec});
		end
	endtask

	// Reset, then offsets 0x00 to 0x1C must read their values after reset
	task automatic reset_test();
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		m_en = 20'h0;
		for (int i = 0; i < 5; i++) m_prio[i] = 16'h4444;
		for (int i = 0; i < 8; i++) begin
			check_reg(8'(4 * i));
		end
		check_irq();
		$display("test reset done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(32'hB6CF));
		reset_test();
		wb(1'b1, 8'h14, 32'hFFFFF, 4'h7);
		for (int s = 0; s < 20; s++) begin
			for (int i = 0; i < 5; i++) wb(1'b1, 8'(4 * i), 32'h0, 4'h3);
			flag <= 20'h1 << s;
			check_irq();
			a = 8'(4 * (s / 4));
			wb(1'b1, a, 32'h1 << (12 - 4 * (s % 4)), 4'h3);
			check_irq();
			wb(1'b1, a, 32'h7 << (12 - 4 * (s % 4)), 4'h3);
			check_irq();
			wb(1'b1, 8'h14, ~(32'h1 << s), 4'h7);
			check_irq();
			wb(1'b1, 8'h14, 32'hFFFFF, 4'h7);
		end
		wb(1'b1, 8'h0C, 32'h0800, 4'h3);
		check_reg(8'h0C);
		$display("test source map done");
		for (int n = 0; n < 40; n++) begin
			a = 8'(4 * ($urandom % 8));
			wb(1'b1, a, $urandom, 4'($urandom));
			check_reg(a);
			flag <= 20'($urandom);
			check_irq();
		end
		$display("test random ranking done");
		reset_test();
		complete_run();
	end
endmodule

// ==== ipb_arbiter.sv ====
/*
 * Registered ranking of pending sources by level, lowest number on ties.
 * Assumes pending already carries the per-source enables.
 */
`timescale 1ns/100ps
module ipb_arbiter (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sources
	input wire ipb_pkg::ipb_levels_t levels_i,
	input wire logic [ipb_pkg::NUM_SRC-1:0] pending_i,
	// Winner
	output logic req_o,
	output logic [2:0] level_o,
	output logic [4:0] vector_o
);

	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic [4:0] vector;
	} ipb_arb_state_t;

	ipb_arb_state_t state;
	ipb_arb_state_t next_state;

	always_comb begin
		next_state = '0;
		next_state.level = ipb_pkg::LVL_OFF;
		for (int i = 0; i < ipb_pkg::NUM_SRC; i++) begin
			// Strictly greater: level 0 never wins, ties keep lower number
			if (pending_i[i] && levels_i[i] > next_state.level) begin // see RQ13
				next_state.level = levels_i[i]; // see RQ1, RQ2
				next_state.vector = 5'(i);
			end
		end
		next_state.req = next_state.level != ipb_pkg::LVL_OFF; // see RQ3
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign req_o = state.req;
	assign level_o = state.level;
	assign vector_o = state.vector;

endmodule

// ==== ipb_cpu_model.sv ====
/*
 * Far-side model: a processor core watching the ranked request.
 * Assumes the request outputs are registered on clk_i.
 */
`timescale 1ns/100ps
module ipb_cpu_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Ranked request
	input wire logic req_i,
	input wire logic [2:0] level_i,
	input wire logic [4:0] vector_i,
	// Requests seen
	output logic [15:0] seen_o,
	output logic [4:0] last_vector_o
);
	// Only a request at a nonzero level is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_o <= 16'h0000;
			last_vector_o <= 5'h00;
		end else if (req_i && level_i != 3'h0) begin
			seen_o <= seen_o + 16'h0001;
			last_vector_o <= vector_i;
		end
	end
endmodule

// ==== ipb_pkg.sv ====
/*
 * Constants, types and helpers of the interrupt priority bank.
 * Assumes a 32-bit classic Wishbone register bus addressed in bytes.
 */
package ipb_pkg;

	localparam int NUM_SRC = 20;
	localparam int NUM_PRIO_REG = 5;
	localparam int SLOTS = 4;

	// Register byte offsets
	localparam logic [NUM_PRIO_REG-1:0][7:0] PRIO_OFS =
		{8'h10, 8'h0C, 8'h08, 8'h04, 8'h00};
	localparam logic [7:0] ENABLE_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;

	// Values after reset, and the mask of implemented field bits
	localparam logic [15:0] PRIO_RST = 16'h4444;
	localparam logic [15:0] PRIO_MASK = 16'h7777;
	localparam logic [NUM_SRC-1:0] ENABLE_RST = 20'h00000;

	// Field positions inside a priority register
	localparam int FIELD_HI_LSB = 12;
	localparam int FIELD_LO_LSB = 0;
	localparam int FIELD_STEP = 4;

	// Status register layout
	localparam int STAT_VEC_LSB = 0;
	localparam int STAT_LVL_LSB = 8;
	localparam int STAT_REQ_BIT = 16;

	// Priority levels
	localparam logic [2:0] LVL_OFF = 3'h0;
	localparam logic [2:0] LVL_MIN = 3'h1;
	localparam logic [2:0] LVL_RST = 3'h4;
	localparam logic [2:0] LVL_MAX = 3'h7;

	typedef logic [NUM_PRIO_REG-1:0][15:0] ipb_prio_regs_t;
	typedef logic [NUM_SRC-1:0][2:0] ipb_levels_t;

	// Source numbers; lower number wins a tie
	typedef enum logic [4:0] {
		SRC_TIMER_A, SRC_COMPARE_OUT_A, SRC_CAPTURE_IN_A,
		SRC_EXTERNAL_IRQ_A,
		SRC_TIMER_B, SRC_COMPARE_OUT_B, SRC_CAPTURE_IN_B, SRC_DMA_CHAN_A,
		SRC_SERIAL_A_RECEIVE, SRC_SYNC_SERIAL_A_TRANSMIT,
		SRC_SYNC_SERIAL_A_GENERAL, SRC_TIMER_C,
		SRC_FLASH_WRITE, SRC_DMA_CHAN_B, SRC_ANALOG_CONVERTER,
		SRC_SERIAL_A_TRANSMIT,
		SRC_PIN_CHANGE, SRC_COMPARATOR, SRC_TWO_WIRE_A_MASTER,
		SRC_TWO_WIRE_A_SLAVE
	} ipb_src_t;

	// Field of one source: slot 0 sits in bits 14-12
	function automatic logic [2:0] field_of(input ipb_prio_regs_t r,
		input int src);
		int reg_n;
		int lsb;
		reg_n = src / SLOTS;
		lsb = FIELD_HI_LSB - (src % SLOTS) * FIELD_STEP;
		return r[reg_n][lsb +: 3];
	endfunction

	function automatic ipb_levels_t levels_of(input ipb_prio_regs_t r);
		ipb_levels_t lv;
		lv = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			lv[i] = field_of(r, i);
		end
		return lv;
	endfunction

	function automatic logic [2:0] max_level(input ipb_levels_t lv,
		input logic [NUM_SRC-1:0] pend);
		logic [2:0] m;
		m = LVL_OFF;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i] && lv[i] > m) begin
				m = lv[i];
			end
		end
		return m;
	endfunction

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge_be(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// ==== ipb_reg_if.sv ====
/*
 * Register access carrier between the bus slave and the register bank.
 * Assumes wr is a one-cycle pulse and rdata is combinational.
 */
`timescale 1ns/100ps
interface ipb_reg_if;
	logic wr;
	logic [7:0] adr;
	logic [31:0] wdata;
	logic [3:0] be;
	logic [31:0] rdata;

	modport bus(output wr, output adr, output wdata, output be,
		input rdata);
	modport bank(input wr, input adr, input wdata, input be,
		output rdata);
endinterface

// ==== ipb_top.sv ====
/*
 * Interrupt priority bank for twenty sources, with enables and ranking.
 * Assumes flags come from logic on clk_i, and a classic Wishbone master.
 */
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps

// Functional notes
// RQ1 - A field of 111 is level 7, the most urgent level.
// RQ2 - A field of 001 is level 1, the least urgent level still served.
// RQ3 - A source whose field is 000 is never forwarded to the processor.
// RQ4 - Bits 15, 11, 7 and 3 of each priority register ignore writes, read 0.
// RQ5 - After reset every field holds 100, level 4.
// RQ6 - Implemented field bits are read/write and read back the last write.
// RQ7 - Register 0 holds timer A, compare A, capture A and external A.
// RQ8 - Register 1 holds timer B, compare B, capture B and DMA channel A.
// RQ9 - Register 2 holds serial A receive, sync serial tx/general, timer C.
// RQ10 - Register 3 holds flash write, DMA channel B, converter, serial A tx.
// RQ11 - Register 4 holds pin change, comparator, two-wire master and slave.
// RQ12 - A source requests service only while its enable bit is one.
// RQ13 - The highest enabled pending level wins, ties to the lower source.
// RQ14 - The flash write field lives in bits 14-12 like all top fields.
module ipb_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Source request flags
	input wire logic [ipb_pkg::NUM_SRC-1:0] flag_i,
	// Request toward the processor
	output logic irq_req_o,
	output logic [2:0] irq_level_o,
	output logic [4:0] irq_vector_o
);

	typedef struct packed {
		ipb_pkg::ipb_prio_regs_t prio;
		logic [ipb_pkg::NUM_SRC-1:0] enable;
	} ipb_bank_state_t;

	ipb_bank_state_t state;
	ipb_bank_state_t next_state;
	ipb_pkg::ipb_levels_t levels;
	logic [ipb_pkg::NUM_SRC-1:0] pending;
	logic arb_req;
	logic [2:0] arb_level;
	logic [4:0] arb_vector;

	ipb_reg_if rif ();

	ipb_wb_slave u_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.regs(rif.bus)
	);

	// Source map; see RQ7, RQ8, RQ9, RQ10, RQ11
	// Level per source, flash field included at bits 14-12
	assign levels = ipb_pkg::levels_of(state.prio); // see RQ14
	// Disabled sources never reach the ranking
	assign pending = flag_i & state.enable; // see RQ12

	ipb_arbiter u_arb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.levels_i(levels),
		.pending_i(pending),
		.req_o(arb_req),
		.level_o(arb_level),
		.vector_o(arb_vector)
	);

	assign irq_req_o = arb_req;
	assign irq_level_o = arb_level;
	assign irq_vector_o = arb_vector;

	// Register writes
	always_comb begin
		logic [31:0] merged;
		merged = '0;
		next_state = state;
		if (rif.wr) begin
			for (int k = 0; k < ipb_pkg::NUM_PRIO_REG; k++) begin
				if (rif.adr == ipb_pkg::PRIO_OFS[k]) begin
					merged = ipb_pkg::merge_be({16'h0000, state.prio[k]},
						rif.wdata, rif.be);
					// Reserved bits stay zero
					next_state.prio[k] = merged[15:0] & ipb_pkg::PRIO_MASK; // see RQ4, RQ6
				end
			end
			if (rif.adr == ipb_pkg::ENABLE_OFS) begin
				merged = ipb_pkg::merge_be({12'h000, state.enable},
					rif.wdata, rif.be);
				next_state.enable = merged[ipb_pkg::NUM_SRC-1:0];
			end
		end
	end

	// Register reads; unmapped offsets read zero
	always_comb begin
		rif.rdata = '0;
		for (int k = 0; k < ipb_pkg::NUM_PRIO_REG; k++) begin
			if (rif.adr == ipb_pkg::PRIO_OFS[k]) begin
				rif.rdata = {16'h0000, state.prio[k] & ipb_pkg::PRIO_MASK}; // see RQ4
			end
		end
		if (rif.adr == ipb_pkg::ENABLE_OFS) begin
			rif.rdata = {12'h000, state.enable};
		end
		if (rif.adr == ipb_pkg::STATUS_OFS) begin
			rif.rdata[ipb_pkg::STAT_REQ_BIT] = arb_req;
			rif.rdata[ipb_pkg::STAT_LVL_LSB +: 3] = arb_level;
			rif.rdata[ipb_pkg::STAT_VEC_LSB +: 5] = arb_vector;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state.prio <= {ipb_pkg::NUM_PRIO_REG{ipb_pkg::PRIO_RST}}; // see RQ5
			state.enable <= ipb_pkg::ENABLE_RST;
		end else begin
			state <= next_state;
		end
	end

	// Checking helpers: inputs of the ranking one cycle back
	ipb_pkg::ipb_levels_t past_levels;
	logic [ipb_pkg::NUM_SRC-1:0] past_pending;
	logic tie_ok;

	always_ff @(posedge clk_i) begin
		past_levels <= levels;
		past_pending <= pending;
	end

	always_comb begin
		tie_ok = 1'b1;
		for (int i = 0; i < ipb_pkg::NUM_SRC; i++) begin
			if (i < int'(irq_vector_o) && past_pending[i] &&
				past_levels[i] == irq_level_o) begin
				tie_ok = 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence max_pending_s(logic [2:0] lvl);
		ipb_pkg::max_level(levels, pending) == lvl;
	endsequence

	sequence no_live_source_s;
		ipb_pkg::max_level(levels, pending) == ipb_pkg::LVL_OFF;
	endsequence

	reset_value_a: assert property ( // see RQ5
		$past(rst_i) |-> (levels[ipb_pkg::SRC_TIMER_A] == ipb_pkg::LVL_RST
		&& state.prio == {ipb_pkg::NUM_PRIO_REG{ipb_pkg::PRIO_RST}}))
		else $error("priority fields not at level 4 after reset");

	top_level_a: assert property ( // see RQ1
		max_pending_s(ipb_pkg::LVL_MAX) |=>
		irq_req_o && irq_level_o == ipb_pkg::LVL_MAX)
		else $error("level 7 source not presented at level 7");

	low_level_a: assert property ( // see RQ2
		max_pending_s(ipb_pkg::LVL_MIN) |=>
		irq_req_o && irq_level_o == ipb_pkg::LVL_MIN)
		else $error("level 1 source not presented at level 1");

	zero_silent_a: assert property ( // see RQ3
		no_live_source_s |=> !irq_req_o)
		else $error("request raised with no nonzero enabled source");

	winner_nonzero_a: assert property ( // see RQ3
		irq_req_o |-> past_levels[irq_vector_o] != ipb_pkg::LVL_OFF &&
		irq_level_o == past_levels[irq_vector_o])
		else $error("winner has level 000 or a mismatched level");

	enable_gate_a: assert property ( // see RQ12
		irq_req_o |-> past_pending[irq_vector_o])
		else $error("request forwarded for a disabled source");

	highest_wins_a: assert property ( // see RQ13
		irq_req_o |-> irq_level_o ==
		ipb_pkg::max_level(past_levels, past_pending) && tie_ok)
		else $error("winner not highest level or lowest number");

	flash_field_a: assert property ( // see RQ14, RQ10
		(rif.wr && rif.adr == ipb_pkg::PRIO_OFS[3] &&
		rif.be[1:0] == 2'h3 && rif.wdata[15:0] == 16'h0800) |=>
		levels[ipb_pkg::SRC_FLASH_WRITE] == ipb_pkg::LVL_OFF &&
		state.prio[3] == 16'h0000)
		else $error("bit 11 leaked into the flash write field");

	sequence enable_write_s;
		rif.wr && rif.adr == ipb_pkg::ENABLE_OFS && rif.be[2:0] == 3'h7;
	endsequence

	reset_quiet_a: assert property ( // see RQ5
		$past(rst_i) |-> !irq_req_o && irq_level_o == ipb_pkg::LVL_OFF &&
		state.enable == ipb_pkg::ENABLE_RST)
		else $error("request or enable not clear after reset");

	idle_zero_a: assert property ( // see RQ3
		!irq_req_o |-> irq_level_o == ipb_pkg::LVL_OFF &&
		irq_vector_o == 5'h00)
		else $error("level or vector shown without a request");

	level_floor_a: assert property ( // see RQ2
		irq_req_o |-> irq_level_o >= ipb_pkg::LVL_MIN)
		else $error("request presented below level 1");

	vector_range_a: assert property ( // see RQ13
		irq_req_o |-> int'(irq_vector_o) < ipb_pkg::NUM_SRC)
		else $error("request vector outside the source range");

	all_disabled_a: assert property ( // see RQ12
		state.enable == '0 |=> !irq_req_o)
		else $error("request raised with every source disabled");

	flag_low_a: assert property ( // see RQ12
		flag_i == '0 |=> !irq_req_o)
		else $error("request raised with no source flag");

	enable_write_a: assert property ( // see RQ12
		enable_write_s |=> state.enable == $past(rif.wdata[19:0]))
		else $error("enable register does not hold last write");

	enable_hold_a: assert property ( // see RQ12
		!(rif.wr && rif.adr == ipb_pkg::ENABLE_OFS) |=>
		state.enable == $past(state.enable))
		else $error("enable register changed without a write");

	prio_hold_a: assert property ( // see RQ6
		!rif.wr |=> state.prio == $past(state.prio))
		else $error("priority register changed without a write");

	status_ro_a: assert property (
		(rif.wr && rif.adr == ipb_pkg::STATUS_OFS) |=>
		state == $past(state))
		else $error("write to the status offset changed a register");

	for (genvar k = 0; k < ipb_pkg::NUM_PRIO_REG; k++) begin : g_chk
		sequence full_write_s;
			rif.wr && rif.adr == ipb_pkg::PRIO_OFS[k] && rif.be[1:0] == 2'h3;
		endsequence

		readback_a: assert property ( // see RQ6
			full_write_s |=> ##1 state.prio[k] ==
			($past(rif.wdata[15:0], 2) & ipb_pkg::PRIO_MASK))
			else $error("priority register does not hold last write");

		field_map_a: assert property ( // see RQ7, RQ8, RQ9, RQ10, RQ11
			full_write_s |=>
			levels[k*4] == $past(rif.wdata[14:12]) &&
			levels[k*4+1] == $past(rif.wdata[10:8]) &&
			levels[k*4+2] == $past(rif.wdata[6:4]) &&
			levels[k*4+3] == $past(rif.wdata[2:0]))
			else $error("written fields not mapped to their sources");

		reserved_zero_a: assert property ( // see RQ4
			(state.prio[k] & ~ipb_pkg::PRIO_MASK) == 16'h0000)
			else $error("reserved priority bit is set");

		sequence lane_write_s(logic [1:0] lanes);
			rif.wr && rif.adr == ipb_pkg::PRIO_OFS[k] && rif.be[1:0] == lanes;
		endsequence

		low_lane_a: assert property ( // see RQ6
			lane_write_s(2'h1) |=>
			state.prio[k][15:8] == $past(state.prio[k][15:8]) &&
			state.prio[k][7:0] ==
			($past(rif.wdata[7:0]) & ipb_pkg::PRIO_MASK[7:0]))
			else $error("lower byte write not applied to its lane only");

		high_lane_a: assert property ( // see RQ6
			lane_write_s(2'h2) |=>
			state.prio[k][7:0] == $past(state.prio[k][7:0]) &&
			state.prio[k][15:8] ==
			($past(rif.wdata[15:8]) & ipb_pkg::PRIO_MASK[15:8]))
			else $error("upper byte write not applied to its lane only");

		read_mask_a: assert property ( // see RQ4
			rif.adr == ipb_pkg::PRIO_OFS[k] |->
			(rif.rdata & ~{16'h0000, ipb_pkg::PRIO_MASK}) == 32'h00000000)
			else $error("reserved or upper bit read back as one");
	end

endmodule

// ==== ipb_wb_slave.sv ====
/*
 * Classic Wishbone slave: one wait state, ack for exactly one cycle.
 * Assumes the master holds its request until it sees ack.
 */
`timescale 1ns/100ps
module ipb_wb_slave (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Register bank side
	ipb_reg_if.bus regs
);

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ipb_wb_state_t;

	ipb_wb_state_t state;
	ipb_wb_state_t next_state;
	logic take;

	// Accept once per request; the ack cycle itself is not a new one
	assign take = wb_cyc_i & wb_stb_i & ~state.ack;
	// A write lands at the edge where the master samples ack
	assign regs.wr = wb_cyc_i & wb_stb_i & wb_we_i & state.ack;
	assign regs.adr = wb_adr_i;
	assign regs.wdata = wb_dat_i;
	assign regs.be = wb_sel_i;

	always_comb begin
		next_state = state;
		next_state.ack = take;
		if (take && !wb_we_i) begin
			next_state.dat = regs.rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.dat;

	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle one clock after request");

endmodule
